//--- verilog/rcf_pkg.sv
`default_nettype none
package rcf_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [3:0] RCF_ADDR_W          = 4'h4;
    localparam logic [3:0] RCF_OFF_CAUSE       = 4'h0; // Reset-cause register
    localparam logic [3:0] RCF_OFF_IRQ_STATUS  = 4'h1; // Sticky event bits
    localparam logic [3:0] RCF_OFF_IRQ_MASK    = 4'h2; // Event enables
    localparam logic [3:0] RCF_OFF_STACK_DEPTH = 4'h3; // Stack fill level

    // --------------------------------------------------------------
    // Reset-cause field positions
    // --------------------------------------------------------------
    localparam int RCF_BIT_OVERFLOW  = 7;
    localparam int RCF_BIT_UNDERFLOW = 6;
    localparam int RCF_BIT_UNUSED    = 5;
    localparam int RCF_BIT_WDT       = 4;
    localparam int RCF_BIT_PIN       = 3;
    localparam int RCF_BIT_SWRST     = 2;
    localparam int RCF_BIT_POR       = 1;
    localparam int RCF_BIT_BROWNOUT  = 0;

    // Writable bits of the cause register (bit 5 excluded)
    localparam logic [7:0] RCF_CAUSE_WMASK = 8'hDF;

    // Values at power-on and brown-out: stack and power flags 0, bits 4 to 2 at 1
    localparam logic [7:0] RCF_CAUSE_PWR_RST = 8'h1C;
    // Value out of the synchronous reset input (no event seen yet)
    localparam logic [7:0] RCF_CAUSE_RST     = 8'h1F;

    // Interrupt status/mask layout: one bit per cause bit
    localparam logic [7:0] RCF_IRQ_RST       = 8'h00;

    // Hardware call stack depth
    localparam int RCF_STACK_DEPTH = 16;
endpackage
`default_nettype wire

//--- verilog/rcf_reset_cause_flags.sv
// How it works
// - Overflow sets bit 7, cleared on power or by firmware
// - Underflow sets bit 6, cleared on power or by firmware
// - Bit 5 reads zero, writes ignored
// - Watchdog reset clears bit 4
// - Pin reset clears bit 3
// - Reset instruction clears bit 2
// - Power-on reset clears bit 1
// - Brown-out reset clears bit 0
// - Power events load stack 0, bits 4 to 2 set to 1
// - Sixteen-entry stack, overrun forces reset
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module rcf_reset_cause_flags #(
    parameter int STACK_DEPTH = rcf_pkg::RCF_STACK_DEPTH
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    input  wire logic       stackPush,
    input  wire logic       stackPop,
    input  wire logic       watchdogEvent,
    input  wire logic       master_clear_pin_n,
    input  wire logic       resetInstr,
    input  wire logic       powerOnEvent,
    input  wire logic       brownoutEvent,
    output logic            stackResetReq,
    output logic            irq
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cause;      // Reset-cause register
        logic [7:0] irqStatus;  // Sticky event bits
        logic [7:0] irqMask;    // Interrupt enables
        logic [4:0] depth;      // Current stack fill level
        logic [7:0] rdData;     // Registered read data
        logic       stkReq;     // Stack fault reset request
        logic       pinSync1;   // First synchroniser stage
        logic       pinSync2;   // Second synchroniser stage
        logic       pinPrev;    // Last synchronised pin level
    } rcf_state_s;

    rcf_state_s state_ff;
    rcf_state_s nxt_state;

    // Event vector placed at the cause bit positions
    logic [7:0] eventVec;
    logic       pinFall;
    logic       overflow;
    logic       underflow;
    logic       powerEvt;

    // Write-one-to-clear helper, used for status clears
    function automatic logic [7:0] rcf_w1c(input logic [7:0] cur,
                                           input logic [7:0] clr);
        rcf_w1c = cur & ~clr;
    endfunction

    // --------------------------------------------------------------
    // Event decode
    // --------------------------------------------------------------
    // Pin is read only after both synchroniser stages
    assign pinFall   = state_ff.pinPrev & ~state_ff.pinSync2;
    // Stack fault: push on full or pop on empty
    assign overflow  = stackPush & ~stackPop
                     & (state_ff.depth == 5'(STACK_DEPTH));
    assign underflow = stackPop & ~stackPush
                     & (state_ff.depth == 5'h00);
    assign powerEvt  = powerOnEvent | brownoutEvent;

    always_comb
    begin
        eventVec = 8'h00;
        eventVec[rcf_pkg::RCF_BIT_OVERFLOW]  = overflow;
        eventVec[rcf_pkg::RCF_BIT_UNDERFLOW] = underflow;
        eventVec[rcf_pkg::RCF_BIT_WDT]       = watchdogEvent;
        eventVec[rcf_pkg::RCF_BIT_PIN]       = pinFall;
        eventVec[rcf_pkg::RCF_BIT_SWRST]     = resetInstr;
        eventVec[rcf_pkg::RCF_BIT_POR]       = powerOnEvent;
        eventVec[rcf_pkg::RCF_BIT_BROWNOUT]  = brownoutEvent;
    end

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    // Firmware write first, hardware events override it afterwards
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.pinSync1 = master_clear_pin_n;
        nxt_state.pinSync2 = state_ff.pinSync1;
        nxt_state.pinPrev  = state_ff.pinSync2;
        nxt_state.rdData   = 8'h00;

        // Stack depth tracking; a fault empties the stack
        if (overflow || underflow)
        begin
            nxt_state.depth = 5'h00;
        end
        else if (stackPush && !stackPop)
        begin
            nxt_state.depth = state_ff.depth + 5'h01;
        end
        else if (stackPop && !stackPush)
        begin
            nxt_state.depth = state_ff.depth - 5'h01;
        end
        nxt_state.stkReq = overflow | underflow;

        // Register writes
        if (regWrite)
        begin
            unique case (regAddr)
                rcf_pkg::RCF_OFF_CAUSE:
                begin
                    // Bit 5 is not stored
                    nxt_state.cause = regWrData
                                    & rcf_pkg::RCF_CAUSE_WMASK;
                end
                rcf_pkg::RCF_OFF_IRQ_STATUS:
                begin
                    nxt_state.irqStatus = rcf_w1c(state_ff.irqStatus,
                                                  regWrData);
                end
                rcf_pkg::RCF_OFF_IRQ_MASK:
                begin
                    nxt_state.irqMask = regWrData
                                      & rcf_pkg::RCF_CAUSE_WMASK;
                end
                default:
                begin
                    // Unmapped or read-only: ignored
                end
            endcase
        end

        // Power events reinitialise all flags but the power-on bit on a brown-out alone
        if (powerEvt)
        begin
            nxt_state.cause = rcf_pkg::RCF_CAUSE_PWR_RST;
            nxt_state.cause[rcf_pkg::RCF_BIT_POR] =
                state_ff.cause[rcf_pkg::RCF_BIT_POR] & ~powerOnEvent;
            nxt_state.cause[rcf_pkg::RCF_BIT_POR] =
                ~powerOnEvent
                & (regWrite && regAddr == rcf_pkg::RCF_OFF_CAUSE
                   ? regWrData[rcf_pkg::RCF_BIT_POR]
                   : state_ff.cause[rcf_pkg::RCF_BIT_POR]);
            nxt_state.cause[rcf_pkg::RCF_BIT_BROWNOUT] = 1'b0;
        end
        else
        begin
            // Events override any same-cycle write
            if (overflow)
            begin
                nxt_state.cause[rcf_pkg::RCF_BIT_OVERFLOW] = 1'b1;
            end
            if (underflow)
            begin
                nxt_state.cause[rcf_pkg::RCF_BIT_UNDERFLOW] = 1'b1;
            end
            if (watchdogEvent)
            begin
                nxt_state.cause[rcf_pkg::RCF_BIT_WDT] = 1'b0;
            end
            if (pinFall)
            begin
                nxt_state.cause[rcf_pkg::RCF_BIT_PIN] = 1'b0;
            end
            if (resetInstr)
            begin
                nxt_state.cause[rcf_pkg::RCF_BIT_SWRST] = 1'b0;
            end
        end
        // Keep the unused bit zero on every path
        nxt_state.cause[rcf_pkg::RCF_BIT_UNUSED] = 1'b0;

        // Sticky status: set wins over a same-cycle clear
        nxt_state.irqStatus = nxt_state.irqStatus | eventVec;

        // Registered read data, one cycle after the strobe
        if (regRead)
        begin
            unique case (regAddr)
                rcf_pkg::RCF_OFF_CAUSE:
                    nxt_state.rdData = state_ff.cause;
                rcf_pkg::RCF_OFF_IRQ_STATUS:
                    nxt_state.rdData = state_ff.irqStatus;
                rcf_pkg::RCF_OFF_IRQ_MASK:
                    nxt_state.rdData = state_ff.irqMask;
                rcf_pkg::RCF_OFF_STACK_DEPTH:
                    nxt_state.rdData = {3'h0, state_ff.depth};
                default:                      nxt_state.rdData = 8'h00;
            endcase
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    // The reset input is the core reset; power events do not use it,
    // they arrive as event inputs and load their values in next-state logic.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff.cause     <= rcf_pkg::RCF_CAUSE_RST;
            state_ff.irqStatus <= rcf_pkg::RCF_IRQ_RST;
            state_ff.irqMask   <= rcf_pkg::RCF_IRQ_RST;
            state_ff.depth     <= 5'h00;
            state_ff.rdData    <= 8'h00;
            state_ff.stkReq    <= 1'b0;
            state_ff.pinSync1  <= 1'b1;
            state_ff.pinSync2  <= 1'b1;
            state_ff.pinPrev   <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign regRdData     = state_ff.rdData;
    assign stackResetReq = state_ff.stkReq;
    assign irq           = |(state_ff.irqStatus & state_ff.irqMask);

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    // A stack overflow leaves its flag set one edge later
    chk_ovf_sets_flag: assert property (
        @(posedge sys_clk) disable iff (reset)
        overflow && !powerEvt
        |=> state_ff.cause[rcf_pkg::RCF_BIT_OVERFLOW])
        else $error("Overflow did not set flag");

    // The overflow flag only falls through a write or a power event
    chk_ovf_flag_sticky: assert property (
        @(posedge sys_clk) disable iff (reset)
        state_ff.cause[rcf_pkg::RCF_BIT_OVERFLOW] && !powerEvt
        && !(regWrite && regAddr == rcf_pkg::RCF_OFF_CAUSE)
        |=> state_ff.cause[rcf_pkg::RCF_BIT_OVERFLOW])
        else $error("Overflow flag lost without a write");

    // A stack underflow leaves its flag set one edge later
    chk_unf_sets_flag: assert property (
        @(posedge sys_clk) disable iff (reset)
        underflow && !powerEvt
        |=> state_ff.cause[rcf_pkg::RCF_BIT_UNDERFLOW])
        else $error("Underflow did not set flag");

    // The underflow flag only falls through a write or a power event
    chk_unf_flag_sticky: assert property (
        @(posedge sys_clk) disable iff (reset)
        state_ff.cause[rcf_pkg::RCF_BIT_UNDERFLOW] && !powerEvt
        && !(regWrite && regAddr == rcf_pkg::RCF_OFF_CAUSE)
        |=> state_ff.cause[rcf_pkg::RCF_BIT_UNDERFLOW])
        else $error("Underflow flag lost without a write");

    // Reads of the cause register never show the unused bit
    chk_unused_bit_zero: assert property (
        @(posedge sys_clk) disable iff (reset)
        $past(regRead) && $past(regAddr) == rcf_pkg::RCF_OFF_CAUSE
        |-> !regRdData[rcf_pkg::RCF_BIT_UNUSED])
        else $error("Bit 5 read nonzero");

    // Watchdog event clears its flag, even against a write
    chk_wdt_clears_flag: assert property (
        @(posedge sys_clk) disable iff (reset)
        watchdogEvent && !powerEvt
        |=> !state_ff.cause[rcf_pkg::RCF_BIT_WDT])
        else $error("Watchdog flag not cleared");

    // Checked on the synchronised level, never on the raw pin
    chk_pin_clears_flag: assert property (
        @(posedge sys_clk) disable iff (reset)
        $fell(state_ff.pinSync2) && !powerEvt
        |=> !state_ff.cause[rcf_pkg::RCF_BIT_PIN])
        else $error("Pin flag not cleared");

    // Reset instruction clears its flag one edge later
    chk_swrst_clears: assert property (
        @(posedge sys_clk) disable iff (reset)
        resetInstr && !powerEvt
        |=> !state_ff.cause[rcf_pkg::RCF_BIT_SWRST])
        else $error("Reset instruction flag not cleared");

    // Power-on clears both power status bits
    chk_por_clears_bit: assert property (
        @(posedge sys_clk) disable iff (reset)
        powerOnEvent
        |=> !state_ff.cause[1] && !state_ff.cause[0])
        else $error("Power-on bits not cleared");

    // Brown-out clears its own status bit
    chk_bor_clears_bit: assert property (
        @(posedge sys_clk) disable iff (reset)
        brownoutEvent
        |=> !state_ff.cause[rcf_pkg::RCF_BIT_BROWNOUT])
        else $error("Brown-out bit not cleared");

    // A brown-out alone must not touch the power-on bit
    chk_bor_keeps_por: assert property (
        @(posedge sys_clk) disable iff (reset)
        brownoutEvent && !powerOnEvent
        && !(regWrite && regAddr == rcf_pkg::RCF_OFF_CAUSE)
        |=> state_ff.cause[rcf_pkg::RCF_BIT_POR]
            == $past(state_ff.cause[rcf_pkg::RCF_BIT_POR]))
        else $error("Brown-out changed power-on bit");

    // Power events load the documented upper flag values
    chk_power_init: assert property (
        @(posedge sys_clk) disable iff (reset)
        powerEvt
        |=> state_ff.cause[7:2] == rcf_pkg::RCF_CAUSE_PWR_RST[7:2])
        else $error("Power init values wrong");

    // Push on a full stack empties it and asks for a reset
    chk_stack_fault: assert property (
        @(posedge sys_clk) disable iff (reset)
        state_ff.depth == 5'(STACK_DEPTH) && stackPush && !stackPop
        |=> stackResetReq && state_ff.depth == 5'h00)
        else $error("Stack overflow not reset");

    // Pop on an empty stack asks for a reset as well
    chk_unf_fault: assert property (
        @(posedge sys_clk) disable iff (reset)
        state_ff.depth == 5'h00 && stackPop && !stackPush
        |=> stackResetReq && state_ff.depth == 5'h00)
        else $error("Stack underflow not reset");

    // Depth never passes the top, or an overflow would go unseen
    chk_depth_bounded: assert property (
        @(posedge sys_clk) disable iff (reset)
        state_ff.depth <= 5'(STACK_DEPTH))
        else $error("Stack depth beyond top");

    // Hardware event wins over a same-cycle firmware write
    chk_event_priority: assert property (
        @(posedge sys_clk) disable iff (reset)
        resetInstr && !powerEvt && regWrite
        && regAddr == rcf_pkg::RCF_OFF_CAUSE
        |=> !state_ff.cause[2] && state_ff.irqStatus[2])
        else $error("Write beat hardware event");
endmodule
`default_nettype wire

//--- dv/test_reset_cause_flags.sv
`timescale 1ns/100ps
`default_nettype none
module test_reset_cause_flags;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic       sysClk      = 1'b0;
    logic       reset       = 1'b1;
    logic [3:0] regAddr     = 4'h0;
    logic [7:0] regWrData   = 8'h00;
    logic       regWrite    = 1'b0;
    logic       regRead     = 1'b0;
    logic [4:0] ev          = 5'h00; // Event pulses, bit 1 unused
    logic       push        = 1'b0;
    logic       pop         = 1'b0;
    logic       pinN        = 1'b1;  // Pin idles released
    logic [7:0] regRdData;
    logic       stackResetReq;
    logic       irq;
    int         mismatches  = 0;
    int         checksDone  = 0;
    int         seed        = 28;
    int         n;
    logic [7:0] d;
    logic [3:0] a;

    // Free-running core clock
    always #20 sysClk = ~sysClk;

    rcf_reset_cause_flags u_dut (
        .sys_clk            (sysClk),
        .reset              (reset),
        .regAddr            (regAddr),
        .regWrData          (regWrData),
        .regWrite           (regWrite),
        .regRead            (regRead),
        .regRdData          (regRdData),
        .stackPush          (push),
        .stackPop           (pop),
        .watchdogEvent      (ev[0]),
        .master_clear_pin_n (pinN),
        .resetInstr         (ev[2]),
        .powerOnEvent       (ev[3]),
        .brownoutEvent      (ev[4]),
        .stackResetReq      (stackResetReq),
        .irq                (irq)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Expected cause value after event k from value c
    function automatic logic [7:0] expCause(input logic [7:0] c,
                                            input int k);
        case (k)
            0:       return c & 8'hEF;
            1:       return c & 8'hF7;
            2:       return c & 8'hFB;
            3:       return 8'h1C;
            default: return 8'h1C | (c & 8'h02); // Power-on bit kept
        endcase
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] e);
        checksDone++;
        if (seen !== e)
        begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, e);
        end
    endtask

    task automatic stopTest;
        $display("Counts: %0d checks, %0d mismatches", checksDone,
                 mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
        @(posedge sysClk);
        regAddr   <= ad;
        regWrData <= dt;
        regWrite  <= 1'b1;
        @(posedge sysClk);
        regWrite  <= 1'b0;
    endtask

    // Read data only stand in the cycle after the strobe
    task automatic rdchk(input logic [3:0] ad, input logic [7:0] e);
        @(posedge sysClk);
        regAddr <= ad;
        regRead <= 1'b1;
        @(posedge sysClk);
        regRead <= 1'b0;
        #1 chk(regRdData, e);
    endtask

    // Event k; the pin goes through a synchroniser, so it stays low
    task automatic fire(input int k);
        @(posedge sysClk);
        if (k == 1)
            pinN <= 1'b0;
        else
            ev[k] <= 1'b1;
        @(posedge sysClk);
        ev <= 5'h00;
        repeat ((k == 1) ? 8 : 0) @(posedge sysClk);
        pinN <= 1'b1;
        repeat ((k == 1) ? 4 : 0) @(posedge sysClk);
    endtask

    task automatic stk(input logic up);
        @(posedge sysClk);
        push <= up;
        pop  <= ~up;
        @(posedge sysClk);
        push <= 1'b0;
        pop  <= 1'b0;
    endtask

    // Bounded wait for the interrupt level
    task automatic irqchk(input logic e);
        #1;
        for (n = 0; n < 4 && irq !== e; n++) @(posedge sysClk);
        chk({7'h00, irq}, {7'h00, e});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge sysClk);
        reset <= 1'b0;
        rdchk(4'h0, rcf_pkg::RCF_CAUSE_RST);
        rdchk(4'h1, 8'h00);
        fire(3);
        rdchk(4'h0, 8'h1C);
        wr(4'h0, 8'hFF);
        rdchk(4'h0, 8'hDF);
        fire(4);
        rdchk(4'h0, expCause(8'hDF, 4));
        $display("test done: power events");
        for (int k = 0; k < 3; k++)
        begin
            wr(4'h0, 8'h1F);
            wr(4'h1, 8'hFF);
            fire(k);
            rdchk(4'h0, expCause(8'h1F, k));
            rdchk(4'h1, ~expCause(8'h1F, k) & 8'h1F);
            irqchk(1'b0);
            wr(4'h2, 8'hFF);
            irqchk(1'b1);
            wr(4'h1, 8'hFF);
            irqchk(1'b0);
            wr(4'h2, 8'h00);
        end
        $display("test done: events and interrupt");
        wr(4'h0, 8'h1F);
        @(posedge sysClk);
        regWrData <= 8'h1F;
        regWrite  <= 1'b1;
        ev        <= 5'h05; // Watchdog and instruction together
        @(posedge sysClk);
        regWrite  <= 1'b0;
        ev        <= 5'h00;
        rdchk(4'h0, 8'h0B);
        rdchk(4'h1, 8'h14);
        wr(4'h0, 8'h1F);
        repeat (16) stk(1'b1);
        rdchk(4'h3, 8'h10);
        stk(1'b1);
        for (n = 0; n < 5 && stackResetReq !== 1'b1; n++) @(posedge sysClk);
        chk({7'h00, stackResetReq}, 8'h01);
        if (n == 5)
            stopTest();
        rdchk(4'h0, 8'h9F);
        rdchk(4'h3, 8'h00);
        stk(1'b0);
        rdchk(4'h0, 8'hDF);
        wr(4'h0, 8'h1F);
        rdchk(4'h0, 8'h1F);
        $display("test done: stack and priority");
        wr(4'h3, 8'h05);
        rdchk(4'h3, 8'h00);
        a = 4'h4;
        repeat (12)
        begin
            wr(a, 8'hFF);
            rdchk(a, 8'h00);
            a++;
        end
        repeat (16)
        begin
            d = 8'($random(seed));
            wr(4'h0, d);
            rdchk(4'h0, d & rcf_pkg::RCF_CAUSE_WMASK);
        end
        $display("test done: map and random writes");
        stopTest();
    end

    // Hang guard
    initial
    begin
        #(40 * 100000);
        mismatches++;
        stopTest();
    end
endmodule
`default_nettype wire
